/* hw/opc_field_reg.sv */
// generic writable field register with reset value
`timescale 1ns/1ns
`default_nettype none
module opc_field_reg #(
  parameter int W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] rst_val_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    q_next = load_i ? data_i : q_reg;
  end

  // reset value comes in on rst_val_i: a tie-off constant, or the span_default_i input for the span
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q_reg <= rst_val_i;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule : opc_field_reg
`default_nettype wire

/* hw/opc_pkg.sv */
// package: register map, field layout and types for the pull control bank
package opc_pkg;

  localparam int          OPC_ADDR_W       = 8;
  localparam int          OPC_DATA_W       = 16;
  localparam int          OPC_WORD_W       = 26;
  localparam int          OPC_LOW_W        = 16;
  localparam int          OPC_HIGH_W       = 10;
  localparam int          OPC_SPAN_W       = 4;

  localparam logic [7:0]  OPC_LOW_OFS      = 8'h00;
  localparam logic [7:0]  OPC_HIGH_OFS     = 8'h01;
  localparam logic [7:0]  OPC_SPAN_OFS     = 8'h02;

  localparam int          OPC_OE_BIT       = 10;

  localparam logic [15:0] OPC_LOW_RST      = 16'h0000;
  localparam logic [9:0]  OPC_HIGH_RST     = 10'h000;
  localparam logic        OPC_OE_RST       = 1'b0;

  // host must not update the word faster than this
  localparam int          OPC_CLK_HZ       = 20000000;
  localparam int          OPC_UPD_MAX_HZ   = 38000;
  localparam int          OPC_UPD_MIN_CYC  = OPC_CLK_HZ / OPC_UPD_MAX_HZ;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } opc_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] rdata;
  } opc_rsp_t;

  typedef enum logic [3:0] {
    OPC_SPAN_6P25, OPC_SPAN_10, OPC_SPAN_12P5, OPC_SPAN_25,
    OPC_SPAN_50, OPC_SPAN_80, OPC_SPAN_100, OPC_SPAN_125,
    OPC_SPAN_150, OPC_SPAN_200, OPC_SPAN_400, OPC_SPAN_600,
    OPC_SPAN_800, OPC_SPAN_1200, OPC_SPAN_1600, OPC_SPAN_3200
  } opc_span_t;

endpackage : opc_pkg

/* hw/opc_pull_regs.sv */
// control register bank of the pullable oscillator
// What this block does
// - the 26-bit offset word is low register 0x00[15:0] plus 0x01[9:0].
// - the combined word is a signed two's complement offset.
// - after reset every bit of the offset word is zero.
// - a low word stays pending until a high word write applies the whole.
// - bit 10 of 0x01 is the software output enable, reset 0.
// - the software enable acts only under software control of enable.
// - bits 15:11 of 0x01 read zero and ignore writes.
// - register 0x02 holds a 4-bit pull span in bits 3:0, rest read zero.
// - the host changes settings by writes and the bank accepts them.
// - span codes 0 to 15 map ascending from 6.25 ppm to 3200 ppm.
// - the pull span resets to a factory constant input.
// - the register side is reached only as a bus slave up to 1 MHz.
`timescale 1ns/1ns
`default_nettype none
module opc_pull_regs
  import opc_pkg::*;
#(
  parameter int MIN_UPD_CYC = OPC_UPD_MIN_CYC
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire opc_req_t              req_i,
  output opc_rsp_t                   rsp_o,
  input  wire logic [OPC_SPAN_W-1:0] span_default_i,
  input  wire logic                  oe_sw_ctrl_i,
  input  wire logic                  oe_pin_i,
  output logic [OPC_WORD_W-1:0]      pull_offset_value_o,
  output logic                       word_update_o,
  output opc_span_t                  span_o,
  output logic                       output_enable_o,
  output logic                       rate_violation_o
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic wr_low;
  logic wr_high;
  logic wr_span;
  logic hit;

  // slave decode only, no master side
  always_comb begin
    hit     = (req_i.addr == OPC_LOW_OFS) || (req_i.addr == OPC_HIGH_OFS)
              || (req_i.addr == OPC_SPAN_OFS);
    wr_low  = req_i.wr && (req_i.addr == OPC_LOW_OFS);
    wr_high = req_i.wr && (req_i.addr == OPC_HIGH_OFS);
    wr_span = req_i.wr && (req_i.addr == OPC_SPAN_OFS);
  end

  ////////////////////////////////////////////////////////////////////////
  // stored fields

  logic [OPC_LOW_W-1:0]  low_offset_word;
  logic [OPC_HIGH_W-1:0] high_offset_word;
  logic [OPC_SPAN_W-1:0] span_q;

  opc_field_reg #(.W(OPC_LOW_W)) u_low (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .rst_val_i (OPC_LOW_RST),
    .load_i    (wr_low),
    .data_i    (req_i.wdata[OPC_LOW_W-1:0]),
    .q_o       (low_offset_word)
  );

  opc_field_reg #(.W(OPC_HIGH_W)) u_high (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .rst_val_i (OPC_HIGH_RST),
    .load_i    (wr_high),
    .data_i    (req_i.wdata[OPC_HIGH_W-1:0]),
    .q_o       (high_offset_word)
  );

  // span reset value is caught by the clocked reset, not asynchronously
  opc_field_reg #(.W(OPC_SPAN_W)) u_span (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .rst_val_i (span_default_i),
    .load_i    (wr_span),
    .data_i    (req_i.wdata[OPC_SPAN_W-1:0]),
    .q_o       (span_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // software enable and applied word

  logic                  oe_sw_reg;
  logic                  oe_sw_next;
  logic [OPC_WORD_W-1:0] applied_reg;
  logic [OPC_WORD_W-1:0] applied_next;
  logic                  upd_reg;
  logic                  upd_next;

  always_comb begin
    oe_sw_next   = oe_sw_reg;
    applied_next = applied_reg;
    upd_next     = 1'b0;
    // under pin control the bit keeps its value
    if (wr_high && oe_sw_ctrl_i) begin
      oe_sw_next = req_i.wdata[OPC_OE_BIT];
    end
    // low word held pending until the high word lands
    if (wr_high) begin
      applied_next = {req_i.wdata[OPC_HIGH_W-1:0], low_offset_word};
      upd_next     = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      oe_sw_reg   <= OPC_OE_RST;
      applied_reg <= '0;
      upd_reg     <= 1'b0;
    end else begin
      oe_sw_reg   <= oe_sw_next;
      applied_reg <= applied_next;
      upd_reg     <= upd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // update spacing monitor

  // a too-fast update is still applied; the flag only reports it
  opc_rate_guard #(.MIN_CYC(MIN_UPD_CYC)) u_guard (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .upd_i      (upd_reg),
    .too_fast_o (rate_violation_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // read path

  logic [OPC_DATA_W-1:0] rdata_reg;
  logic [OPC_DATA_W-1:0] rdata_next;
  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic                  rerr_reg;
  logic                  rerr_next;

  always_comb begin
    rdata_next  = '0;
    rvalid_next = req_i.rd;
    rerr_next   = (req_i.rd || req_i.wr) && !hit;
    if (req_i.rd) begin
      unique case (req_i.addr)
        OPC_LOW_OFS:  rdata_next = low_offset_word;
        // upper bits stay zero
        OPC_HIGH_OFS: rdata_next = {5'h00, oe_sw_reg, high_offset_word};
        OPC_SPAN_OFS: rdata_next = {12'h000, span_q};
        default:      rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      rerr_reg   <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      rerr_reg   <= rerr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    rsp_o.valid = rvalid_reg;
    rsp_o.err   = rerr_reg;
    rsp_o.rdata = rdata_reg;
  end

  // signed offset, msb is the sign
  assign pull_offset_value_o = applied_reg;
  assign word_update_o       = upd_reg;
  assign span_o              = opc_span_t'(span_q);
  assign output_enable_o     = oe_sw_ctrl_i ? oe_sw_reg : oe_pin_i;

endmodule : opc_pull_regs
`default_nettype wire

/* hw/opc_rate_guard.sv */
// flags frequency updates that arrive closer than the minimum spacing
`timescale 1ns/1ns
`default_nettype none
module opc_rate_guard
  import opc_pkg::*;
#(
  parameter int MIN_CYC = OPC_UPD_MIN_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic upd_i,
  output logic      too_fast_o
);

  localparam int CW = $clog2(MIN_CYC + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          fast_reg;
  logic          fast_next;

  always_comb begin
    cnt_next  = cnt_reg;
    fast_next = fast_reg;
    if (upd_i) begin
      if (cnt_reg != '0) begin
        fast_next = 1'b1;
      end
      cnt_next = CW'(MIN_CYC - 1);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_reg  <= '0;
      fast_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      fast_reg <= fast_next;
    end
  end

  assign too_fast_o = fast_reg;

endmodule : opc_rate_guard
`default_nettype wire

/* tb/opc_host_model.sv */
// partner model: bus host issuing one register request at a time
`timescale 1ns/1ns
`default_nettype none
module opc_host_model
  import opc_pkg::*;
#(
  parameter int GAP = 8
) (
  input  wire logic     sys_clk_i,
  input  wire opc_rsp_t rsp_i,
  output var  opc_req_t req_o
);
  opc_rsp_t last;
  initial req_o = '0;
  // request held through its taking edge, then dropped
  // fast skips the spacing on purpose, to provoke the rate flag
  task automatic xfer(input logic w, input logic fast,
                      input logic [7:0] a, input logic [15:0] d);
    if (w && !fast && a == OPC_HIGH_OFS) begin
      repeat (GAP) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    #1 req_o = '{w, !w, a, d};
    @(posedge sys_clk_i);
    // idle bus shows inverted fields, not stale ones
    #1 req_o = {2'b00, ~a, ~d};
    last = rsp_i;
  endtask : xfer
endmodule : opc_host_model
`default_nettype wire

/* tb/opc_pull_regs_sva.sv */
// checker: port relations of the pull control register bank
`timescale 1ns/1ns
`default_nettype none
module opc_pull_regs_chk
  import opc_pkg::*;
#(
  parameter int MIN_UPD_CYC = OPC_UPD_MIN_CYC
) (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire opc_req_t              req_i,
  input wire opc_rsp_t              rsp_o,
  input wire logic [OPC_SPAN_W-1:0] span_default_i,
  input wire logic                  oe_sw_ctrl_i,
  input wire logic                  oe_pin_i,
  input wire logic [OPC_WORD_W-1:0] pull_offset_value_o,
  input wire logic                  word_update_o,
  input wire opc_span_t             span_o,
  input wire logic                  output_enable_o,
  input wire logic                  rate_violation_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic hi_wr = req_i.wr && req_i.addr == OPC_HIGH_OFS;
  ////////////////////////////////////////
  a_upd_on_high: assert property (hi_wr |=> word_update_o)
    else $error("no update after high write");
  a_upd_only_high: assert property (!hi_wr |=> !word_update_o)
    else $error("stray update");
  a_word_apply: assert property (hi_wr |=>
    pull_offset_value_o[25:16] == $past(req_i.wdata[9:0]))
    else $error("high word not applied");
  a_word_hold: assert property (!word_update_o |->
    $stable(pull_offset_value_o)) else $error("word moved");
  a_rst_zero: assert property ($fell(rst_i) |->
    pull_offset_value_o == '0 && span_o == span_default_i)
    else $error("bad reset state");
  a_rd_answer: assert property (req_i.rd |=> rsp_o.valid)
    else $error("read not answered");
  a_oe_hw_pin: assert property (!oe_sw_ctrl_i |->
    output_enable_o == oe_pin_i) else $error("enable not from pin");
  a_high_rd_zero: assert property (req_i.rd &&
    req_i.addr == OPC_HIGH_OFS |=> rsp_o.rdata[15:11] == '0)
    else $error("unused bits read nonzero");
  a_span_write: assert property (req_i.wr &&
    req_i.addr == OPC_SPAN_OFS |=> span_o == $past(req_i.wdata[3:0]))
    else $error("span not written");
  a_viol_sticky: assert property (rate_violation_o |=>
    rate_violation_o) else $error("rate flag dropped");
  c_update: cover property (word_update_o);
  c_too_fast: cover property ($rose(rate_violation_o));
  c_read: cover property (rsp_o.valid);
  c_refused: cover property (rsp_o.err);
endmodule : opc_pull_regs_chk
bind opc_pull_regs opc_pull_regs_chk #(.MIN_UPD_CYC(MIN_UPD_CYC)) i_chk (
  .sys_clk_i, .rst_i, .req_i, .rsp_o, .span_default_i, .oe_sw_ctrl_i,
  .oe_pin_i, .pull_offset_value_o, .word_update_o, .span_o,
  .output_enable_o, .rate_violation_o);
`default_nettype wire

/* tb/testbench.sv */
// testbench: register bank scenarios driven through the host model
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import opc_pkg::*;
  localparam logic [3:0] SPAN_DEF = 4'h9;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        sw_ctrl = 1'b1;
  logic        pin     = 1'b0;
  opc_req_t    req;
  opc_rsp_t    rsp;
  logic [25:0] word;
  logic        upd;
  logic        oe;
  opc_span_t   span;
  logic        viol;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  always #25 sys_clk = ~sys_clk;
  opc_pull_regs #(.MIN_UPD_CYC(8)) i_opc_pull_regs (.sys_clk_i(sys_clk),
    .rst_i(rst), .req_i(req), .rsp_o(rsp), .span_default_i(SPAN_DEF),
    .oe_sw_ctrl_i(sw_ctrl), .oe_pin_i(pin), .pull_offset_value_o(word),
    .word_update_o(upd), .span_o(span), .output_enable_o(oe),
    .rate_violation_o(viol));
  opc_host_model #(.GAP(8)) i_opc_host_model (.sys_clk_i(sys_clk),
    .rsp_i(rsp), .req_o(req));
  ////////////////////////////////////////
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_opc_host_model.xfer(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic wr_fast(input logic [7:0] a, input logic [15:0] d);
    i_opc_host_model.xfer(1'b1, 1'b1, a, d);
  endtask : wr_fast
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    i_opc_host_model.xfer(1'b0, 1'b0, a, 16'h0000);
    chk(i_opc_host_model.last.valid, 1'b1);
    chk(i_opc_host_model.last.rdata, e);
  endtask : rd
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  task automatic do_reset();
    @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk(word, '0);
    chk(span, SPAN_DEF);
    chk(oe, 1'b0);
    chk(viol, 1'b0);
    rd(OPC_HIGH_OFS, 16'h0000);
    rd(OPC_LOW_OFS, 16'h0000);
  endtask : do_reset
  task automatic t_word();
    wr(OPC_LOW_OFS, 16'h6666);
    chk(upd, 1'b0);
    chk(word, '0);
    rd(OPC_LOW_OFS, 16'h6666);
    wr(OPC_HIGH_OFS, 16'hffe6);
    chk(upd, 1'b1);
    chk(word, 26'h3e66666);
    chk(word[25], 1'b1);
    chk(oe, 1'b1);
    rd(OPC_HIGH_OFS, 16'h07e6);
    // high word alone reuses the stored low word
    wr(OPC_HIGH_OFS, 16'h0001);
    chk(word, 26'h0016666);
    chk(oe, 1'b0);
  endtask : t_word
  task automatic t_oe();
    sw_ctrl = 1'b0;
    wr(OPC_HIGH_OFS, 16'h0400);
    chk(oe, 1'b0);
    rd(OPC_HIGH_OFS, 16'h0000);
    pin = 1'b1;
    #1 chk(oe, 1'b1);
    sw_ctrl = 1'b1;
    #1 chk(oe, 1'b0);
  endtask : t_oe
  task automatic t_span();
    for (int c = 0; c < 16; c++) begin
      wr(OPC_SPAN_OFS, {12'hfff, c[3:0]});
      chk(span, c[3:0]);
      rd(OPC_SPAN_OFS, {12'h000, c[3:0]});
    end
    chk(span, OPC_SPAN_3200);
    wr(8'h03, 16'h1234);
    chk(i_opc_host_model.last.err, 1'b1);
    chk(span, OPC_SPAN_3200);
  endtask : t_span
  // host breaks the spacing here on purpose; flag sticks until reset
  task automatic t_rate();
    chk(viol, 1'b0);
    wr(OPC_HIGH_OFS, 16'h0002);
    wr_fast(OPC_HIGH_OFS, 16'h0003);
    chk(word, 26'h0036666);
    @(posedge sys_clk);
    #1 chk(viol, 1'b1);
  endtask : t_rate
  ////////////////////////////////////////
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    do_reset();
    t_word();
    t_oe();
    t_span();
    t_rate();
    do_reset();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
